//--- ptb_defs.vh
// Purpose: constants for the periodic time base timer
// Assumes: 8-bit register port, 100 MHz system clock
// Notes: offsets are byte addresses on the register port
`ifndef PTB_DEFS_VH
`define PTB_DEFS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define PTB_ADDR_W 8
`define PTB_OFF_CTRL 8'h36
`define PTB_OFF_STAT 8'h40
`define PTB_OFF_MASK 8'h41
`define PTB_OFF_MODE 8'h42

// ------------------------------------------------------------
// control fields and reset values
// ------------------------------------------------------------
`define PTB_CTRL_RST 8'h00
`define PTB_BIT_DIVOUT_EN 7
`define PTB_BIT_DIVOUT_FREQ_HI 6
`define PTB_BIT_DIVOUT_FREQ_LO 5
`define PTB_BIT_STAGE 4
`define PTB_BIT_EN 3
`define PTB_BIT_TAP_HI 2
`define PTB_BIT_TAP_LO 0
`define PTB_STAT_RST 1'b0
`define PTB_MASK_RST 1'b0
`define PTB_MODE_RST 1'b0

// ------------------------------------------------------------
// divider
// ------------------------------------------------------------
`define PTB_DIV_W 23
`define PTB_LF_DIV_W 15

`endif

//--- ptb_sync.v
// Purpose: two-flop synchroniser for one level
// Assumes: async active-low reset
// Notes: first flop read only by second
`timescale 1ns/1ps
module ptb_sync (
   // clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // data
   input wire d_i,
   output reg q_o
);
   reg meta_r;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= 1'b0;
         q_o <= 1'b0;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule

//--- ptb_tap_mux.v
// Purpose: registered selection of one divider tap
// Assumes: divider vectors synchronous to sys clock
// Notes: output is one cycle behind the divider
`timescale 1ns/1ps
`include "ptb_defs.vh"
module ptb_tap_mux (
   // clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // selection
   input wire lf_sel_i,
   input wire [2:0] tap_i,
   // divider state
   input wire [`PTB_DIV_W-1:0] main_div_i,
   input wire [`PTB_LF_DIV_W-1:0] lf_div_i,
   // selected tap
   output reg tap_o
);
   reg tap_nxt;
   always @* begin
      tap_nxt = 1'b0;
      if (lf_sel_i) begin
         case (tap_i)
            3'd0: tap_nxt = lf_div_i[14];
            3'd1: tap_nxt = lf_div_i[12];
            3'd2: tap_nxt = lf_div_i[7];
            3'd3: tap_nxt = lf_div_i[5];
            3'd4: tap_nxt = lf_div_i[4];
            3'd5: tap_nxt = lf_div_i[3];
            3'd6: tap_nxt = lf_div_i[2];
            default: tap_nxt = lf_div_i[0];
         endcase
      end else begin
         case (tap_i)
            3'd0: tap_nxt = main_div_i[22];
            3'd1: tap_nxt = main_div_i[20];
            3'd2: tap_nxt = main_div_i[15];
            3'd3: tap_nxt = main_div_i[13];
            3'd4: tap_nxt = main_div_i[12];
            3'd5: tap_nxt = main_div_i[11];
            3'd6: tap_nxt = main_div_i[10];
            default: tap_nxt = main_div_i[8];
         endcase
      end
   end
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tap_o <= 1'b0;
      end else begin
         tap_o <= tap_nxt;
      end
   end
endmodule

//--- ptb_timer.v
// Purpose: periodic time base interrupt generator with register port
// Assumes: low-frequency clock arrives as a level, sampled by sys clock
// Notes: divider output fields are stored but drive nothing here
`timescale 1ns/1ps
`include "ptb_defs.vh"
module ptb_timer (
   // clock and reset
   input wire sys_clk_i,
   input wire rst_n_i,
   // low frequency clock level
   input wire low_freq_clock_i,
   // register port
   input wire [`PTB_ADDR_W-1:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [7:0] reg_rdata_o,
   // interrupt controller
   output reg periodic_interrupt_o,
   output reg irq_o
);
   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   reg rst_s1_r;
   reg rst_s2_r;
   wire rst_n;
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign rst_n = rst_s2_r;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg [7:0] time_base_control_r;
   reg stat_r;
   reg mask_r;
   reg slow_mode_r;
   wire periodic_timer_enable;
   wire divider_stage_select;
   wire [2:0] interrupt_tap_select;
   wire wr_ctrl;
   wire wr_stat;
   wire wr_mask;
   wire wr_mode;
   reg tick_r;

   assign periodic_timer_enable = time_base_control_r[`PTB_BIT_EN];
   assign divider_stage_select = time_base_control_r[`PTB_BIT_STAGE];
   assign interrupt_tap_select = time_base_control_r[`PTB_BIT_TAP_HI:`PTB_BIT_TAP_LO];
   assign wr_ctrl = reg_wr_i && (reg_addr_i == `PTB_OFF_CTRL);
   assign wr_stat = reg_wr_i && (reg_addr_i == `PTB_OFF_STAT);
   assign wr_mask = reg_wr_i && (reg_addr_i == `PTB_OFF_MASK);
   assign wr_mode = reg_wr_i && (reg_addr_i == `PTB_OFF_MODE);

   always @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         time_base_control_r <= `PTB_CTRL_RST;
         mask_r <= `PTB_MASK_RST;
         slow_mode_r <= `PTB_MODE_RST;
      end else begin
         // tap and enable in one write
         if (wr_ctrl) begin
            time_base_control_r <= reg_wdata_i;
         end
         if (wr_mask) begin
            mask_r <= reg_wdata_i[0];
         end
         if (wr_mode) begin
            slow_mode_r <= reg_wdata_i[0];
         end
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `PTB_OFF_CTRL: reg_rdata_o <= time_base_control_r;
            `PTB_OFF_STAT: reg_rdata_o <= {7'h00, stat_r};
            `PTB_OFF_MASK: reg_rdata_o <= {7'h00, mask_r};
            `PTB_OFF_MODE: reg_rdata_o <= {7'h00, slow_mode_r};
            default: reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // free-running dividers
   // ------------------------------------------------------------
   reg [`PTB_DIV_W-1:0] main_div_r;
   reg [`PTB_LF_DIV_W-1:0] lf_div_r;
   wire lf_lvl;
   reg lf_prev_r;

   ptb_sync u_lf_sync (
      .clk_i(sys_clk_i),
      .rst_n_i(rst_n),
      .d_i(low_freq_clock_i),
      .q_o(lf_lvl)
   );

   always @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         main_div_r <= {`PTB_DIV_W{1'b0}};
         lf_div_r <= {`PTB_LF_DIV_W{1'b0}};
         lf_prev_r <= 1'b0;
      end else begin
         main_div_r <= main_div_r + {{(`PTB_DIV_W-1){1'b0}}, 1'b1};
         lf_prev_r <= lf_lvl;
         if (lf_lvl && !lf_prev_r) begin
            lf_div_r <= lf_div_r + {{(`PTB_LF_DIV_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // ------------------------------------------------------------
   // tap selection and edge detect
   // ------------------------------------------------------------
   wire lf_sel;
   wire tap;
   reg tap_prev_r;
   reg tick_nxt;
   reg [3:0] sel_d1_r;
   reg [3:0] sel_d2_r;

   // low clock source in stage or slow mode
   assign lf_sel = divider_stage_select | slow_mode_r;

   ptb_tap_mux u_tap (
      .clk_i(sys_clk_i),
      .rst_n_i(rst_n),
      .lf_sel_i(lf_sel),
      .tap_i(interrupt_tap_select),
      .main_div_i(main_div_r),
      .lf_div_i(lf_div_r),
      .tap_o(tap)
   );

   always @* begin
      tick_nxt = 1'b0;
      // no false edge on tap switch
      if (periodic_timer_enable && tap_prev_r && !tap && (sel_d1_r == sel_d2_r)) begin
         tick_nxt = 1'b1;
      end
   end

   always @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tap_prev_r <= 1'b0;
         tick_r <= 1'b0;
         periodic_interrupt_o <= 1'b0;
         sel_d1_r <= 4'h0;
         sel_d2_r <= 4'h0;
      end else begin
         tap_prev_r <= tap;
         // selection seen by tap and by tap_prev
         sel_d1_r <= {lf_sel, interrupt_tap_select};
         sel_d2_r <= sel_d1_r;
         tick_r <= tick_nxt;
         periodic_interrupt_o <= tick_nxt;
      end
   end

   // ------------------------------------------------------------
   // interrupt status and mask
   // ------------------------------------------------------------
   always @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         stat_r <= `PTB_STAT_RST;
         irq_o <= 1'b0;
      end else begin
         // set wins over clear
         if (tick_r) begin
            stat_r <= 1'b1;
         end else if (wr_stat && reg_wdata_i[0]) begin
            stat_r <= 1'b0;
         end
         irq_o <= stat_r & mask_r;
      end
   end
endmodule

//--- ptb_timer_monitor.sv
// Purpose: port checker for ptb_timer
// Assumes: shadow of control, mask and mode bits
// Notes: bound from the testbench top
`timescale 1ns/1ps
`include "ptb_defs.vh"
module ptb_timer_chk (
   // clock and reset
   input wire sys_clk_i,
   input wire rst_n_i,
   // register port
   input wire [`PTB_ADDR_W-1:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_rdata_o,
   // interrupt
   input wire periodic_interrupt_o,
   input wire irq_o
);
   // ------------------------------
   // shadow state
   // ------------------------------
   localparam int EXP [8] = '{23, 21, 16, 14, 13, 12, 11, 9};
   logic [7:0] ctrl_r;
   logic mask_r, mode_r, seen_r;
   logic [2:0] dis_r;
   logic [23:0] gap_r;
   wire wr_ctrl = reg_wr_i && reg_addr_i == `PTB_OFF_CTRL;
   wire wr_mode = reg_wr_i && reg_addr_i == `PTB_OFF_MODE;
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_r <= 8'h00;
         mask_r <= 1'b0;
         mode_r <= 1'b0;
         seen_r <= 1'b0;
         dis_r <= 3'd7;
         gap_r <= 24'h0;
      end else begin
         if (wr_ctrl) ctrl_r <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == `PTB_OFF_MASK) mask_r <= reg_wdata_i[0];
         if (wr_mode) mode_r <= reg_wdata_i[0];
         seen_r <= (periodic_interrupt_o || seen_r) && !wr_ctrl && !wr_mode;
         dis_r <= ctrl_r[3] ? 3'd0 : (dis_r == 3'd7 ? 3'd7 : dis_r + 3'd1);
         gap_r <= periodic_interrupt_o ? 24'h0 : gap_r + 24'h1;
      end
   end
   // ------------------------------
   // assertions
   // ------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_ctrl_wr;
      wr_ctrl;
   endsequence
   sequence s_ctrl_rd;
      reg_rd_i && reg_addr_i == `PTB_OFF_CTRL;
   endsequence
   a_pulse_one_cycle: assert property (periodic_interrupt_o |=> !periodic_interrupt_o)
      else $error("pulse longer than one cycle");
   a_no_pulse_off: assert property (dis_r == 3'd7 |-> !periodic_interrupt_o)
      else $error("pulse while disabled");
   a_ctrl_readback: assert property (s_ctrl_wr ##2 s_ctrl_rd |=> reg_rdata_o == $past(reg_wdata_i, 3))
      else $error("control readback wrong");
   a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("read data outside read cycle");
   a_reset_quiet: assert property ($rose(rst_n_i) |-> !periodic_interrupt_o && !irq_o)
      else $error("outputs active after reset");
   a_tap_period: assert property (periodic_interrupt_o && seen_r && !ctrl_r[4] && !mode_r
      |-> gap_r == 24'((1 << EXP[ctrl_r[2:0]]) - 1))
      else $error("interrupt period wrong");
   a_irq_follows: assert property (periodic_interrupt_o && mask_r |-> ##[1:2] irq_o)
      else $error("irq missing after event");
   a_irq_clear: assert property (reg_wr_i && reg_addr_i == `PTB_OFF_STAT && reg_wdata_i[0]
      && !periodic_interrupt_o |=> ##1 !irq_o)
      else $error("irq stays after clear");
endmodule

//--- ptb_timer_tb_top.sv
// Purpose: self-checking bench for ptb_timer
// Assumes: low clock period 20 system cycles
// Notes: periods measured between pulses
`timescale 1ns/1ps
`include "ptb_defs.vh"
module ptb_timer_tb_top;
   // ------------------------------
   // stimulus and tasks
   // ------------------------------
   localparam int EXP [8] = '{23, 21, 16, 14, 13, 12, 11, 9};
   logic clk = 0, rst_n = 0, lfc = 0, wr = 0, rd = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00;
   wire [7:0] rdata;
   wire pint, irq;
   int bad_count = 0, checks = 0;
   always #5 clk = ~clk;
   always #100 lfc = ~lfc;
   ptb_timer dut (.sys_clk_i(clk), .rst_n_i(rst_n), .low_freq_clock_i(lfc), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .periodic_interrupt_o(pint), .irq_o(irq));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wreg(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(logic [7:0] a, logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk("rdata", {24'h0, e}, {24'h0, rdata});
   endtask
   task automatic wait_pulse(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (pint !== 1'b1 && n < 20000);
      if (pint !== 1'b1) begin
         bad_count++;
         end_sim;
      end
   endtask
   initial begin
      int n;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rreg(`PTB_OFF_CTRL, `PTB_CTRL_RST);
      rreg(8'h37, 8'h00);
      wreg(`PTB_OFF_CTRL, 8'hff);
      rreg(`PTB_OFF_CTRL, 8'hff);
      wreg(`PTB_OFF_MODE, 8'h01);
      rreg(`PTB_OFF_MODE, 8'h01);
      wreg(`PTB_OFF_MODE, 8'h00);
      wreg(`PTB_OFF_CTRL, 8'h07);
      wreg(`PTB_OFF_MASK, 8'h01);
      wreg(`PTB_OFF_STAT, 8'h01);
      for (int t = 4; t < 8; t++) begin
         wreg(`PTB_OFF_CTRL, 8'h08 | 8'(t));
         wait_pulse(n);
         chk("first", 1, n <= (1 << EXP[t]));
         wait_pulse(n);
         chk("period", 1 << EXP[t], n);
         wreg(`PTB_OFF_CTRL, 8'(t));
      end
      chk("irq", 1, irq);
      wreg(`PTB_OFF_STAT, 8'h01);
      rreg(`PTB_OFF_STAT, 8'h00);
      chk("irq", 0, irq);
      n = 0;
      repeat (1100) @(negedge clk) n += pint;
      chk("idle", 0, n);
      wreg(`PTB_OFF_MASK, 8'h00);
      wreg(`PTB_OFF_CTRL, 8'h1f);
      wait_pulse(n);
      wait_pulse(n);
      chk("low", 40, n);
      rreg(`PTB_OFF_STAT, 8'h01);
      chk("masked", 0, irq);
      wreg(`PTB_OFF_CTRL, 8'h17);
      end_sim;
   end
endmodule
bind ptb_timer ptb_timer_chk u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .periodic_interrupt_o(periodic_interrupt_o), .irq_o(irq_o));
